/* core/port_defs.vh */
/*
 * Register map, field positions and reset values of the four-bit port.
 * Assumes an APB master with 32-bit data and word-aligned registers.
 */
`ifndef PORT_DEFS_VH
`define PORT_DEFS_VH
// What this block does
// - Four pins; pins 0 to 2 each usable as input or output under its own direction bit.
// - A direction bit of one makes the pin an input with its driver off.
// - A direction bit of zero drives the pin from its output latch.
// - One pin is input only and its direction bit always reads one.
// - Data reads return pin levels while data writes load the latch.
// - Each data write stores a read-modify-write of the pin levels.
// - The input-only pin reads zero while its external reset use is on.
// - An analog-selected pin reads zero on every digital read.
// - Analog select leaves the digital output path untouched.
// - Direction bits govern the drivers even on analog pins.
// - Reset sets every analog-select bit; software clears it for digital use.
// - Pin outputs come only from the latch, with no peripheral mux.

`define PORT_DATA_ADDR    12'h000
`define PORT_DIR_ADDR     12'h004
`define PORT_ANALOG_INPUT_SELECT_ADDR   12'h008
`define PORT_LATCH_ADDR   12'h00C
`define PORT_CFG_ADDR     12'h010

`define PORT_WIDTH        4
`define PORT_IN_ONLY_BIT  3
`define PORT_CFG_RSTEN_BIT 0

`define PORT_DIR_RST      4'hF
`define PORT_ANALOG_INPUT_SELECT_RST    4'hF
`define PORT_LATCH_RST    4'h0
`define PORT_CFG_RST      1'b0
`endif

/* core/port_gpio.v */
/*
 * Four-bit bidirectional port with per-pin direction, latch and analog
 * select, reached over APB. Pin inputs are taken as synchronous to pclk.
 */
`timescale 1ns/1ps
`include "port_defs.vh"

module port_gpio #(
	parameter W = `PORT_WIDTH
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire [W-1:0]  pin_in,
	output reg  [W-1:0]  pin_out,
	output reg  [W-1:0]  pin_oe
);

////////////////////////////////////////////////////////////////////////////
// Bus decode and write fields

localparam [11:0]  ADDR_DATA  = `PORT_DATA_ADDR;
localparam [11:0]  ADDR_DIR   = `PORT_DIR_ADDR;
localparam [11:0]  ADDR_ANALOG_INPUT_SELECT = `PORT_ANALOG_INPUT_SELECT_ADDR;
localparam [11:0]  ADDR_LATCH = `PORT_LATCH_ADDR;
localparam [11:0]  ADDR_CFG   = `PORT_CFG_ADDR;
localparam         IN_ONLY    = `PORT_IN_ONLY_BIT;
localparam         RSTEN_BIT  = `PORT_CFG_RSTEN_BIT;

localparam [W-1:0] DIR_RST    = `PORT_DIR_RST;
localparam [W-1:0] ANALOG_INPUT_SELECT_RST  = `PORT_ANALOG_INPUT_SELECT_RST;
localparam [W-1:0] LATCH_RST  = `PORT_LATCH_RST;

wire         setup;
wire         access;
wire         wr_go;
wire         rd_go;
wire         sel_data;
wire         sel_dir;
wire         sel_analog_input_select;
wire         sel_latch;
wire         sel_cfg;
wire         sel_hit;
wire [W-1:0] wr_value;
wire [W-1:0] wr_mask;
wire         wr_rsten;

wire [W-1:0] digital_in;
wire [W-1:0] dir_view;
wire [W-1:0] analog_input_select_vec;
wire [W-1:0] latch_vec;

reg          rsten_q;
reg          rsten_d;
reg  [31:0]  rdata_d;
reg          pready_d;
reg          pslverr_d;
reg  [31:0]  prdata_d;
reg  [W-1:0] pin_out_d;
reg  [W-1:0] pin_oe_d;

assign setup     = psel & ~penable;
// Writes land only at the edge where the master sees pready
assign access    = psel & penable & pready;
assign wr_go     = access & pwrite;
assign rd_go     = setup & ~pwrite;

// Address decode; any other address is refused
assign sel_data  = (paddr == ADDR_DATA);
assign sel_dir   = (paddr == ADDR_DIR);
assign sel_analog_input_select = (paddr == ADDR_ANALOG_INPUT_SELECT);
assign sel_latch = (paddr == ADDR_LATCH);
assign sel_cfg   = (paddr == ADDR_CFG);
assign sel_hit   = sel_data | sel_dir | sel_analog_input_select | sel_latch | sel_cfg;

// Write fields: data writes carry a bit-select mask above the values
assign wr_value  = pwdata[W-1:0];
assign wr_mask   = pwdata[2*W-1:W];
assign wr_rsten  = pwdata[RSTEN_BIT];

////////////////////////////////////////////////////////////////////////////
// Configuration: external reset use of the input-only pin

// Reset use blanks that pin's read level, which unmasked data writes also copy into its latch
always @* begin
	rsten_d = rsten_q;
	if (wr_go && sel_cfg) begin
		rsten_d = wr_rsten;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rsten_q <= `PORT_CFG_RST;
	end else begin
		rsten_q <= rsten_d;
	end
end

////////////////////////////////////////////////////////////////////////////
// Per-pin state

genvar i;
generate
	for (i = 0; i < W; i = i + 1) begin : g_pin
		reg  dir_bit_q;
		reg  dir_bit_d;
		reg  analog_input_select_bit_q;
		reg  analog_input_select_bit_d;
		reg  latch_bit_q;
		reg  latch_bit_d;
		wire level;
		wire view_dir;
		wire dir_we;
		wire analog_input_select_we;
		wire data_we;
		wire latch_we;
		wire value_bit;
		wire mask_bit;

		assign dir_we    = wr_go & sel_dir;
		assign analog_input_select_we  = wr_go & sel_analog_input_select;
		assign data_we   = wr_go & sel_data;
		assign latch_we  = wr_go & sel_latch;
		assign value_bit = wr_value[i];
		assign mask_bit  = wr_mask[i];

		// Direction bit
		always @* begin
			dir_bit_d = dir_bit_q;
			if (dir_we) begin
				dir_bit_d = value_bit;
			end
		end

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dir_bit_q <= DIR_RST[i];
			end else begin
				dir_bit_q <= dir_bit_d;
			end
		end

		// Analog select bit
		always @* begin
			analog_input_select_bit_d = analog_input_select_bit_q;
			if (analog_input_select_we) begin
				analog_input_select_bit_d = value_bit;
			end
		end

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				analog_input_select_bit_q <= ANALOG_INPUT_SELECT_RST[i];
			end else begin
				analog_input_select_bit_q <= analog_input_select_bit_d;
			end
		end

		// Output latch; unselected bits take the pin level, not the latch,
		// so an analog output pin loses its latch value on a data write
		always @* begin
			latch_bit_d = latch_bit_q;
			if (data_we) begin
				if (mask_bit) begin
					latch_bit_d = value_bit;
				end else begin
					latch_bit_d = digital_in[i];
				end
			end else if (latch_we) begin
				latch_bit_d = value_bit;
			end
		end

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				latch_bit_q <= LATCH_RST[i];
			end else begin
				latch_bit_q <= latch_bit_d;
			end
		end

		// Digital read path
		if (i == IN_ONLY) begin : g_in_only
			// Stored direction bit is ignored: this pin never drives
			assign view_dir = 1'b1;
			assign level    = pin_in[i] & ~analog_input_select_bit_q & ~rsten_q;
		end else begin : g_bidir
			assign view_dir = dir_bit_q;
			assign level    = pin_in[i] & ~analog_input_select_bit_q;
		end

		assign dir_view[i]   = view_dir;
		assign analog_input_select_vec[i]  = analog_input_select_bit_q;
		assign latch_vec[i]  = latch_bit_q;
		assign digital_in[i] = level;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Register read words

wire [31:0]  data_word;
wire [31:0]  dir_word;
wire [31:0]  analog_input_select_word;
wire [31:0]  latch_word;
wire [31:0]  cfg_word;

assign data_word  = {{(32-W){1'b0}}, digital_in};
assign dir_word   = {{(32-W){1'b0}}, dir_view};
assign analog_input_select_word = {{(32-W){1'b0}}, analog_input_select_vec};
assign latch_word = {{(32-W){1'b0}}, latch_vec};
assign cfg_word   = {31'h00000000, rsten_q} << RSTEN_BIT;

////////////////////////////////////////////////////////////////////////////
// Read mux

always @* begin
	rdata_d = 32'h00000000;
	case (paddr)
		ADDR_DATA: begin
			rdata_d = data_word;
		end

		ADDR_DIR: begin
			rdata_d = dir_word;
		end

		ADDR_ANALOG_INPUT_SELECT: begin
			rdata_d = analog_input_select_word;
		end

		ADDR_LATCH: begin
			rdata_d = latch_word;
		end

		ADDR_CFG: begin
			rdata_d = cfg_word;
		end

		default: begin
			rdata_d = 32'h00000000;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////
// APB answer: one access cycle after every setup, no wait states

// Next state
always @* begin
	pready_d  = setup;
	pslverr_d = setup & ~sel_hit;
	prdata_d  = prdata;
	if (rd_go) begin
		prdata_d = rdata_d;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		pready  <= pready_d;
		pslverr <= pslverr_d;
	end
end

// Read data holds until the next read, so it stands in the access cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else begin
		prdata <= prdata_d;
	end
end

////////////////////////////////////////////////////////////////////////////
// Pin drivers: latch only, analog select plays no part

// Next state
always @* begin
	pin_out_d = latch_vec;
	pin_oe_d  = ~dir_view;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pin_out <= {W{1'b0}};
		pin_oe  <= {W{1'b0}};
	end else begin
		pin_out <= pin_out_d;
		pin_oe  <= pin_oe_d;
	end
end

endmodule // port_gpio

/* tb/port_props.sv */
/* Port assertions. Assumes the APB timing of the port contract. */
`timescale 1ns/1ps
module port_props(input wire pclk,presetn,psel,penable,pwrite,pready,
	pslverr,input wire [11:0] paddr,input wire [31:0] pwdata,prdata,
	input wire [3:0] pin_in,pin_out,pin_oe);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire su = psel && !penable;
	wire wr = psel && penable && pready && pwrite;
	AST_RDY: assert property (su |=> pready) else $error("no ready");
	AST_ERR: assert property (su && paddr > 12'h010 |=> pslverr)
		else $error("no slverr");
	AST_OE3: assert property (!pin_oe[3]) else $error("pin3 driven");
	AST_DIR: assert property (wr && paddr == 12'h004 |->
		##2 pin_oe[2:0] == ~$past(pwdata[2:0], 2)) else $error("bad oe");
	AST_LAT: assert property (wr && paddr == 12'h00C |->
		##2 pin_out == $past(pwdata[3:0], 2)) else $error("bad out");
	AST_SRC: assert property ($changed(pin_out) |-> $past(wr, 2))
		else $error("stray out");
	AST_DRD: assert property (pready && !pwrite && paddr == 12'h004
		|-> prdata[3]) else $error("dir3 low");
	AST_HI: assert property (pready && !pwrite |-> !prdata[31:4])
		else $error("high bits");
endmodule // port_props
bind port_gpio port_props u_port_props(.*);

/* tb/pin_board.sv */
/* Board side of the pins. Assumes a source on every released pin. */
`timescale 1ns/1ps
module pin_board(input wire [3:0] pin_out,pin_oe,ext,
	output wire [3:0] pin_in);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pin_board

/* tb/testbench.sv */
/* Port bench, APB master plus board model. Assumes nothing else. */
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr;
	logic [3:0] pin_in, pin_out, pin_oe, ext = '0;
	int failures = 0, num_checks = 0;
	// w, addr, wdata, ext, expected read
	logic [31:0] rows [18] = '{32'h0000_0F00, 32'h0040_0F0F,
		32'h0080_0F0F, 32'h1080_0F00, 32'h0000_0A0A, 32'h1040_0A00,
		32'h10C0_5A00, 32'h0000_080D, 32'h1100_1800, 32'h0000_0805,
		32'h1002_2800, 32'h00C0_0807, 32'h1080_1800, 32'h0000_0006,
		32'h1004_4000, 32'h00C0_0006, 32'h0040_0008, 32'h0200_0000};
	always #4 pclk = ~pclk;
	port_gpio u_port_gpio(.*);
	pin_board u_pin_board(.*);
	task automatic apb(input [11:0] a, input w, input [31:0] d);
		int n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1 && ++n < 50);
		if (n >= 50) failures++;
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task chk(input [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		foreach (rows[i]) begin
			ext <= rows[i][11:8];
			apb(rows[i][27:20], rows[i][28], rows[i][19:12]);
			if (!rows[i][28]) chk(r, rows[i][7:0]);
		end
		chk({pin_oe, pin_out}, 8'h76);
		apb(12'h014, 1, 5);
		chk(err, 1);
		presetn <= 0;
		@(posedge pclk) presetn <= 1;
		@(posedge pclk);
		apb(12'h008, 0, 0);
		chk(r, 15);
		chk(pin_oe, 0);
		finish_test;
	end
	initial begin
		#20000 failures++;
		finish_test;
	end
endmodule // testbench
